// file: verilog/shsm_defs.svh
// Constants of the shifter buffer and state sequencer: register map, field positions,
// reset values and sizes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SHSM_DEFS_SVH
`define SHSM_DEFS_SVH

// Sizes
`define SHSM_NUM          8
`define SHSM_PTR_W        3
`define SHSM_ADR_W        12
`define SHSM_PIN_W        32

// Register map: single registers by byte address, register arrays by 32-byte page
`define SHSM_ADR_STATUS   12'h010
`define SHSM_ADR_STATE    12'h014
`define SHSM_PAGE_CTRL    7'h04
`define SHSM_PAGE_BUF     7'h08

// Fields of each shifter control register
`define SHSM_CTL_MODE_LSB 0
`define SHSM_CTL_TSEL_LSB 4
`define SHSM_CTL_PIN_LSB  8
`define SHSM_CTL_INPUT_SOURCE_SELECT    13
`define SHSM_CTL_TRIG     14
`define SHSM_CTL_W        15

// Fields of the buffer word
`define SHSM_BUF_OUT_LSB  24
`define SHSM_BUF_HI_LSB   16

// Reset values
`define SHSM_RST_CTRL     15'h0000
`define SHSM_RST_BUF      32'h0000_0000
`define SHSM_RST_STATE    3'h0

`endif

// file: verilog/shsm_pkg.sv
// Types shared by the shifter buffer and state sequencer modules.
// Assumes shsm_defs.svh on the include path.
`default_nettype none
`include "shsm_defs.svh"

package shsm_pkg;

    // Shifter mode select field encodings
    typedef enum logic [2:0] {
        SHSM_MODE_DIS   = 3'b000,
        SHSM_MODE_RX    = 3'b001,
        SHSM_MODE_TX    = 3'b010,
        SHSM_MODE_RSVD  = 3'b011,
        SHSM_MODE_MSTO  = 3'b100,
        SHSM_MODE_MCON  = 3'b101,
        SHSM_MODE_STATE = 3'b110,
        SHSM_MODE_LOGIC = 3'b111
    } shsm_mode_t;

endpackage : shsm_pkg

`default_nettype wire

// file: verilog/shsm_lane.sv
// Per-shifter combinational evaluation of the buffer word: masked match,
// lookup-table output and next-state selection.
// Assumes the caller registers every result it drives out.
`timescale 1ns/1ps
`default_nettype none

module shsm_lane
    import shsm_pkg::*;
(
    // Buffer and shifter contents
    input  wire logic [31:0] buf_i,
    input  wire logic [31:0] shift_i,
    // Selectors
    input  wire logic [4:0]  logic_in_i,
    input  wire logic [2:0]  state_in_i,
    // Results
    output logic             match_o,
    output logic             logic_o,
    output logic [2:0]       next_state_o
);

    logic [15:0] diff;

    // Upper half is compare data, lower half masks: a 1 ignores that bit
    always_comb begin
        diff    = (shift_i[31:16] ^ buf_i[31:16]) & ~buf_i[15:0];
        match_o = (diff == 16'h0000);
    end

    // Whole word is a 32-entry table indexed by five inputs
    always_comb begin
        logic_o = buf_i[logic_in_i];
    end

    // Lower 24 bits hold eight 3-bit next-state groups, picked by the inputs
    always_comb begin
        next_state_o = buf_i[{state_in_i, 2'b00} - {2'b00, state_in_i} +: 3];
    end

endmodule : shsm_lane

`default_nettype wire

// file: verilog/shsm_top.sv
// Shifter buffer words, their mode-dependent use and the state sequencer built on them,
// with a classic Wishbone register slave.
// Assumes timer expiry and timer start arrive as one-cycle pulses synchronous to CORE_CLK_I
// and that the shift engines outside present their current contents continuously.
// Summary of operation
// - Receive: timer expiry copies shifter into buffer.
// - Transmit: buffer loads shifter when timer starts.
// - Match store: upper compare, lower mask, on expiry.
// - Match event writes shifter upper half to buffer.
// - Match continuous compares every cycle, mask ones.
// - Logic mode: buffer is 5-input lookup table.
// - Selected state shifter drives outputs from top byte.
// - Lower 24 bits hold next-state table.
// - Advance pointer only on selected timer expiry.
// - Timer comes from current state's select field.
// - Flag set while pointer selects the shifter.
// - Flag clears when pointer moves elsewhere.
// - State flag usable as interrupt/DMA request.
// - Entering chosen state may pulse output trigger.
// - Mode field encodes eight modes, zero to seven.
// - State inputs pick a 3-bit next-state group.
// - Pointer resets zero; software write overrides it.
// - State inputs from pins or next shifter.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "shsm_defs.svh"

module shsm_top
    import shsm_pkg::*;
#(
    parameter int NSH = `SHSM_NUM // Must match the 3-bit state pointer
) (
    // Clock and reset
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  RESETN_I,
    // Wishbone slave
    input  wire logic                  WB_CYC_I,
    input  wire logic                  WB_STB_I,
    input  wire logic                  WB_WE_I,
    input  wire logic [`SHSM_ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]            WB_SEL_I,
    input  wire logic [31:0]           WB_DAT_I,
    output logic [31:0]                WB_DAT_O,
    output logic                       WB_ACK_O,
    // Timers
    input  wire logic [NSH-1:0]        TIMER_EXPIRE_I,
    input  wire logic [NSH-1:0]        TIMER_START_I,
    // Shift engines
    input  wire logic [NSH*32-1:0]     SHIFT_DATA_I,
    output logic [NSH-1:0]             SHIFT_LOAD_O,
    output logic [NSH*32-1:0]          SHIFT_LOAD_DATA_O,
    // Pins and lookup inputs
    input  wire logic [`SHSM_PIN_W-1:0] PIN_I,
    input  wire logic [NSH*5-1:0]      LOGIC_IN_I,
    // Results
    output logic [NSH-1:0]             MATCH_O,
    output logic [NSH-1:0]             LOGIC_OUT_O,
    output logic [7:0]                 STATE_OUT_O,
    output logic [NSH-1:0]             STATUS_REQ_O,
    output logic                       TRIGGER_O,
    output logic [`SHSM_PTR_W-1:0]     STATE_PTR_O
);

    // Storage
    logic [31:0]                buf_r   [NSH];
    logic [`SHSM_CTL_W-1:0]     ctrl_r  [NSH];
    logic [NSH-1:0]             flag_r;
    logic [`SHSM_PTR_W-1:0]     state_ptr_r;
    logic [`SHSM_PTR_W-1:0]     state_ptr_nxt;
    logic [7:0]                 state_out_r;
    logic                       trig_r;
    logic [NSH-1:0]             load_r;
    logic [NSH*32-1:0]          load_data_r;
    logic [NSH-1:0]             match_r;
    logic [NSH-1:0]             logic_r;
    logic                       ack_r;
    logic [31:0]                dat_r;

    // Decoded access
    logic                       acc;
    logic                       wr;
    logic                       rd;
    logic [2:0]                 idx;
    logic                       hit_status;
    logic                       hit_state;
    logic                       hit_ctrl;
    logic                       hit_buf;
    logic [31:0]                rd_data;
    logic [31:0]                ctrl_merged;

    // Per-shifter results
    shsm_mode_t                 mode    [NSH];
    logic [2:0]                 tsel    [NSH];
    logic [2:0]                 next_st [NSH];
    logic [NSH-1:0]             hit;
    logic [NSH-1:0]             lout;

    // Sequencer terms
    shsm_mode_t                 cur_mode;
    logic                       advance;

    // Byte-lane merge of a software write
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Address decode; ack is withheld in the cycle it is high so each access answers once
    always_comb begin
        acc        = WB_CYC_I & WB_STB_I & ~ack_r;
        wr         = acc & WB_WE_I;
        rd         = acc & ~WB_WE_I;
        idx        = WB_ADR_I[4:2];
        hit_status = 1'b0;
        hit_state  = 1'b0;
        hit_ctrl   = 1'b0;
        hit_buf    = 1'b0;
        if (WB_ADR_I == `SHSM_ADR_STATUS) begin
            hit_status = 1'b1;
        end else if (WB_ADR_I == `SHSM_ADR_STATE) begin
            hit_state = 1'b1;
        end else if (WB_ADR_I[11:5] == `SHSM_PAGE_CTRL && WB_ADR_I[1:0] == 2'b00) begin
            hit_ctrl = 1'b1;
        end else if (WB_ADR_I[11:5] == `SHSM_PAGE_BUF && WB_ADR_I[1:0] == 2'b00) begin
            hit_buf = 1'b1;
        end
    end

    // Read mux; unmapped addresses read as zero and are still acknowledged
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_status) begin
            rd_data = {{(32-NSH){1'b0}}, flag_r};
        end else if (hit_state) begin
            rd_data = {29'h0, state_ptr_r};
        end else if (hit_ctrl) begin
            rd_data = {{(32-`SHSM_CTL_W){1'b0}}, ctrl_r[idx]};
        end else if (hit_buf) begin
            rd_data = buf_r[idx];
        end
    end

    // Lane merge of the addressed control word, widened to 32 bits for be_merge; buffer writes do their own merge
    always_comb begin
        ctrl_merged = be_merge({{(32-`SHSM_CTL_W){1'b0}}, ctrl_r[idx]}, WB_DAT_I, WB_SEL_I);
    end

    // Bus answer: one cycle after the request, dropped the cycle after
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc;
            if (rd) begin
                dat_r <= rd_data;
            end
        end
    end

    // Control registers, written by byte lane
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (int n = 0; n < NSH; n++) begin
                ctrl_r[n] <= `SHSM_RST_CTRL;
            end
        end else if (wr && hit_ctrl) begin
            ctrl_r[idx] <= ctrl_merged[`SHSM_CTL_W-1:0];
        end
    end

    // Sequencer: only a state-mode shifter under the pointer can advance it
    always_comb begin
        cur_mode = mode[state_ptr_r];
        advance  = (cur_mode == SHSM_MODE_STATE) &&
                   TIMER_EXPIRE_I[tsel[state_ptr_r]];
        state_ptr_nxt = state_ptr_r;
        if (wr && hit_state && WB_SEL_I[0]) begin
            state_ptr_nxt = WB_DAT_I[2:0];
        end else if (advance) begin
            state_ptr_nxt = next_st[state_ptr_r];
        end
    end

    // Pointer, outputs and trigger move on the one edge that also moves the flags
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_ptr_r <= `SHSM_RST_STATE;
            state_out_r <= 8'h00;
            trig_r      <= 1'b0;
        end else begin
            state_ptr_r <= state_ptr_nxt;
            if (mode[state_ptr_nxt] == SHSM_MODE_STATE) begin
                state_out_r <= buf_r[state_ptr_nxt][`SHSM_BUF_OUT_LSB +: 8];
            end
            trig_r <= (state_ptr_nxt != state_ptr_r) &&
                      (mode[state_ptr_nxt] == SHSM_MODE_STATE) &&
                      ctrl_r[state_ptr_nxt][`SHSM_CTL_TRIG];
        end
    end

    // One lane per shifter
    for (genvar n = 0; n < NSH; n++) begin : g_sh
        logic [31:0] shift;
        logic [2:0]  st_in;
        logic [63:0] pins2;
        logic        expire;
        logic        start;
        logic        sw_buf_wr;
        logic        sw_buf_rd;
        logic        set_ev;
        logic        clr_ev;

        // Mode field maps straight onto the enum encodings
        always_comb begin
            mode[n]   = shsm_mode_t'(ctrl_r[n][`SHSM_CTL_MODE_LSB +: 3]);
            tsel[n]   = ctrl_r[n][`SHSM_CTL_TSEL_LSB +: 3];
            shift     = SHIFT_DATA_I[n*32 +: 32];
            expire    = TIMER_EXPIRE_I[tsel[n]];
            start     = TIMER_START_I[tsel[n]];
            sw_buf_wr = wr && hit_buf && (idx == 3'(n));
            sw_buf_rd = rd && hit_buf && (idx == 3'(n));
        end

        // State inputs: three pins from the base (wrapping) or the next shifter's LSBs
        always_comb begin
            pins2 = {PIN_I, PIN_I} >> ctrl_r[n][`SHSM_CTL_PIN_LSB +: 5];
            if (ctrl_r[n][`SHSM_CTL_INPUT_SOURCE_SELECT]) begin
                st_in = SHIFT_DATA_I[((n + 1) % NSH)*32 +: 3];
            end else begin
                st_in = pins2[2:0];
            end
        end

        shsm_lane u_lane (
            .buf_i        (buf_r[n]),
            .shift_i      (shift),
            .logic_in_i   (LOGIC_IN_I[n*5 +: 5]),
            .state_in_i   (st_in),
            .match_o      (hit[n]),
            .logic_o      (lout[n]),
            .next_state_o (next_st[n])
        );

        // Buffer word: hardware capture beats a software write in the same cycle
        always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                buf_r[n] <= `SHSM_RST_BUF;
            end else if (mode[n] == SHSM_MODE_RX && expire) begin
                buf_r[n] <= shift;
            end else if (mode[n] == SHSM_MODE_MSTO && expire && hit[n]) begin
                buf_r[n][31:`SHSM_BUF_HI_LSB] <= shift[31:`SHSM_BUF_HI_LSB];
            end else if (sw_buf_wr) begin
                buf_r[n] <= be_merge(buf_r[n], WB_DAT_I, WB_SEL_I);
            end
        end

        // Flag events per mode; a buffer access or a write-one to status clears
        always_comb begin
            set_ev = 1'b0;
            case (mode[n])
                SHSM_MODE_RX:   set_ev = expire;
                SHSM_MODE_TX:   set_ev = start;
                SHSM_MODE_MSTO: set_ev = expire & hit[n];
                SHSM_MODE_MCON: set_ev = hit[n];
                default:        set_ev = 1'b0;
            endcase
            clr_ev = sw_buf_rd | sw_buf_wr |
                     (wr && hit_status && WB_SEL_I[n/8] && WB_DAT_I[n]);
        end

        // In state mode the flag follows the pointer; elsewhere set wins over clear
        always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                flag_r[n] <= 1'b0;
            end else if (mode[n] == SHSM_MODE_STATE) begin
                flag_r[n] <= (state_ptr_nxt == 3'(n));
            end else begin
                flag_r[n] <= set_ev | (flag_r[n] & ~clr_ev);
            end
        end

        // Transmit load pulses the cycle after the timer start, before it shifts anything
        always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                load_r[n]              <= 1'b0;
                load_data_r[n*32 +: 32] <= 32'h0000_0000;
            end else begin
                load_r[n] <= (mode[n] == SHSM_MODE_TX) && start;
                if ((mode[n] == SHSM_MODE_TX) && start) begin
                    load_data_r[n*32 +: 32] <= buf_r[n];
                end
            end
        end

        // Registered match and lookup results
        always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                match_r[n] <= 1'b0;
                logic_r[n] <= 1'b0;
            end else begin
                match_r[n] <= (mode[n] == SHSM_MODE_MCON) && hit[n];
                logic_r[n] <= (mode[n] == SHSM_MODE_LOGIC) && lout[n];
            end
        end
    end

    // Outputs
    assign WB_DAT_O          = dat_r;
    assign WB_ACK_O          = ack_r;
    assign SHIFT_LOAD_O      = load_r;
    assign SHIFT_LOAD_DATA_O = load_data_r;
    assign MATCH_O           = match_r;
    assign LOGIC_OUT_O       = logic_r;
    assign STATE_OUT_O       = state_out_r;
    assign STATUS_REQ_O      = flag_r;
    assign TRIGGER_O         = trig_r;
    assign STATE_PTR_O       = state_ptr_r;

endmodule : shsm_top

`default_nettype wire

// file: verification/shsm_props.sv
// Checker on the sequencer top ports: bus handshake, state advance, shifter load.
// Assumes binding to shsm_top with one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "shsm_defs.svh"
module shsm_props #(
    parameter int NSH = 8
) (
    // Clock and reset
    input wire logic                   CORE_CLK_I,
    input wire logic                   RESETN_I,
    // Bus
    input wire logic                   WB_CYC_I,
    input wire logic                   WB_STB_I,
    input wire logic                   WB_WE_I,
    input wire logic [`SHSM_ADR_W-1:0] WB_ADR_I,
    input wire logic [31:0]            WB_DAT_O,
    input wire logic                   WB_ACK_O,
    // Timers and results
    input wire logic [NSH-1:0]         TIMER_EXPIRE_I,
    input wire logic [NSH-1:0]         TIMER_START_I,
    input wire logic [NSH-1:0]         SHIFT_LOAD_O,
    input wire logic [NSH*32-1:0]      SHIFT_LOAD_DATA_O,
    input wire logic [7:0]             STATE_OUT_O,
    input wire logic                   TRIGGER_O,
    input wire logic [`SHSM_PTR_W-1:0] STATE_PTR_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // A taken write may legally move any output, so it counts as a cause
    logic wr_take;
    assign wr_take = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_ack_pulse;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    property p_ack_once;
        s_req |=> s_ack_pulse;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not one cycle after request");
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_unmapped;
        s_req ##0 (!WB_WE_I && WB_ADR_I < 12'h010) |=> WB_DAT_O == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ptr_cause;
        $changed(STATE_PTR_O) |-> $past(|TIMER_EXPIRE_I) || $past(wr_take);
    endproperty
    a_ptr_cause: assert property (p_ptr_cause) else $error("pointer moved alone");
    property p_out_cause;
        // A buffer or control write of the current state shows up two edges later
        $changed(STATE_OUT_O) |-> $past(|TIMER_EXPIRE_I) || $past(wr_take) ||
                                  $past(wr_take, 2);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("outputs moved alone");
    property p_trig_cause;
        TRIGGER_O |-> $past(|TIMER_EXPIRE_I) || $past(wr_take);
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without entry");
    property p_load_cause;
        |SHIFT_LOAD_O |-> $past(|TIMER_START_I);
    endproperty
    a_load_cause: assert property (p_load_cause) else $error("load without start");
    property p_load_hold;
        !(|SHIFT_LOAD_O) |-> $stable(SHIFT_LOAD_DATA_O);
    endproperty
    a_load_hold: assert property (p_load_hold) else $error("load data moved");
endmodule : shsm_props
bind shsm_top shsm_props #(.NSH(NSH)) shsm_props_i (.*);
`default_nettype wire

// file: verification/shsm_far.sv
// Far-side model: timers pulsing expiry or start, and the shift engines' contents.
// Assumes calls to its tasks are made just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module shsm_far (
    // Clock
    input  wire logic    clk_i,
    // Timer events and shifter contents
    output logic [7:0]   exp_o,
    output logic [7:0]   start_o,
    output logic [255:0] shd_o
);
    // Single-cycle events; a slow timer waits dly cycles first
    task automatic pulse(input logic st, input int t, input int dly);
        repeat (dly) @(posedge clk_i);
        if (st) begin
            start_o[t] <= 1'b1;
        end else begin
            exp_o[t] <= 1'b1;
        end
        @(posedge clk_i);
        exp_o   <= 8'h00;
        start_o <= 8'h00;
    endtask : pulse
    // Contents are levels held until the next change
    task automatic put(input int n, input logic [31:0] v);
        shd_o[n*32 +: 32] <= v;
    endtask : put
    // Quiet timers at start
    initial begin
        exp_o   = 8'h00;
        start_o = 8'h00;
        shd_o   = '0;
    end
endmodule : shsm_far
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench: bus tasks configure and read, the far model times events.
// Assumes shsm_top, shsm_far and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic         clk, rst_n, cyc, stb, we, ack, trig;
    logic [11:0]  adr;
    logic [31:0]  dat, rdat, q, pin;
    logic [7:0]   expi, starti, load, match, lout, sreq, sout;
    logic [255:0] shd, ldat;
    logic [39:0]  lin;
    logic [2:0]   ptr, pp;
    int           bad_count, tests_run;
    logic [11:0]  za [6] = '{12'h004, 12'h102, 12'h080, 12'h100, 12'h014, 12'h010};
    logic [43:0]  cfg [15] = '{{12'h080, 32'h0000_1e16}, {12'h084, 32'h0000_0021},
        {12'h088, 32'h0000_0032}, {12'h08c, 32'h0000_0044}, {12'h090, 32'h0000_0005},
        {12'h094, 32'h0000_0007}, {12'h098, 32'h0000_2026}, {12'h09c, 32'h0000_4006},
        {12'h100, 32'ha500_01c6}, {12'h108, 32'hcafe_0123}, {12'h10c, 32'hab00_00ff},
        {12'h110, 32'h5555_0000}, {12'h114, 32'h0000_0020}, {12'h118, 32'h3c00_0e00},
        {12'h11c, 32'h8100_0000}};
    int           st_tm [4] = '{1, 2, 0, 1};
    logic [2:0]   st_ptr [4] = '{3'd6, 3'd7, 3'd0, 3'd7};
    logic [7:0]   st_out [4] = '{8'h3c, 8'h81, 8'ha5, 8'h81};
    logic         st_trg [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    shsm_top shsm_top_i (.CORE_CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .TIMER_EXPIRE_I(expi), .TIMER_START_I(starti), .SHIFT_DATA_I(shd),
        .SHIFT_LOAD_O(load), .SHIFT_LOAD_DATA_O(ldat), .PIN_I(pin), .LOGIC_IN_I(lin),
        .MATCH_O(match), .LOGIC_OUT_O(lout), .STATE_OUT_O(sout), .STATUS_REQ_O(sreq),
        .TRIGGER_O(trig), .STATE_PTR_O(ptr));
    shsm_far far_i (.clk_i(clk), .exp_o(expi), .start_o(starti), .shd_o(shd));

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle; held until ack is sampled, then released
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) chk(32'h0, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // Watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        summarize();
    end
    // Main sequence
    initial begin
        {rst_n, cyc, stb, we, adr, dat, pin, lin, bad_count, tests_run} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Writes to unmapped or misaligned places are dropped
        wb(1'b1, 12'h004, 32'hffff_ffff);
        wb(1'b1, 12'h102, 32'hffff_ffff);
        foreach (za[k]) begin
            wb(1'b0, za[k], 32'h0);
            chk(q, 32'h0);
        end
        foreach (cfg[k]) wb(1'b1, cfg[k][43:32], cfg[k][31:0]);
        // Timer 2 is not the state timer of shifter 0: capture but no advance
        far_i.put(1, 32'h1234_abcd);
        far_i.pulse(1'b0, 2, 0);
        @(posedge clk);
        chk(32'(ptr), 32'h0);
        wb(1'b0, 12'h010, 32'h0);
        chk(q & 32'h2, 32'h2);
        wb(1'b0, 12'h104, 32'h0);
        chk(q, 32'h1234_abcd);
        // Slow timer start loads the transmit shifter
        far_i.pulse(1'b1, 3, 2);
        @(posedge clk);
        chk(32'(load), 32'h4);
        chk(ldat[64 +: 32], 32'hcafe_0123);
        // Unmasked miss keeps the buffer, masked hit stores the upper half
        for (int k = 0; k < 2; k++) begin
            far_i.put(3, k ? 32'hab5a_0000 : 32'hac5a_0000);
            far_i.pulse(1'b0, 4, 0);
            wb(1'b0, 12'h10c, 32'h0);
            chk(q, k ? 32'hab5a_00ff : 32'hab00_00ff);
        end
        // Continuous compare and lookup output, miss then hit
        for (int k = 0; k < 2; k++) begin
            far_i.put(4, k ? 32'h5555_1234 : 32'h5554_1234);
            lin[25 +: 5] <= k ? 5'd5 : 5'd4;
            repeat (3) @(posedge clk);
            chk(32'({match[4], lout[5]}), k ? 32'h3 : 32'h0);
        end
        // State walk: pins wrap at base 30, shifter 6 reads shifter 7's low bits
        far_i.put(7, 32'h0000_0003);
        pp = 3'd0;
        for (int k = 0; k < 4; k++) begin
            if (k == 3) pin <= 32'h8000_0000;
            far_i.pulse(1'b0, st_tm[k], 1);
            @(posedge clk);
            chk(32'({ptr, sout, trig}), 32'({st_ptr[k], st_out[k], st_trg[k]}));
            chk(32'({sreq[st_ptr[k]], sreq[pp]}), 32'h2);
            pp = st_ptr[k];
        end
        // Software write overrides the pointer
        wb(1'b1, 12'h014, 32'h0000_0006);
        wb(1'b0, 12'h014, 32'h0);
        chk(q, 32'h0000_0006);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
